// ---- rtl/spio_pkg.sv ----
`default_nettype none
package spio_pkg;
  localparam int DATA_W = 32;
  localparam int PORT_W = 16;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_PIN = 8'h04;
  localparam logic [7:0] OFS_STORE = 8'h08;
  localparam logic [7:0] OFS_ANALOG = 8'h0C;
  localparam logic [7:0] OFS_PERIPH = 8'h10;
  localparam logic [15:0] DIR_RESET = 16'hFFFF;
  localparam logic [15:0] STORE_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_RESET = 16'h0000;
  localparam logic [15:0] IMPL_MASK_DEF = 16'hFFFF;
  localparam logic [15:0] SHARED_MASK_DEF = 16'hFFFF;
endpackage
`default_nettype wire

// ---- rtl/spio_port.sv ----
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spio_port #(
  parameter logic [15:0] IMPL_MASK = spio_pkg::IMPL_MASK_DEF,
  parameter logic [15:0] SHARED_MASK = spio_pkg::SHARED_MASK_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] padIn,
  output logic [15:0] padOut,
  output logic [15:0] padOutEn_n,
  input wire logic [15:0] periphEnable,
  input wire logic [15:0] periphActive,
  input wire logic [15:0] periphOut,
  input wire logic [15:0] periphOutEn_n
);
  logic [15:0] dirSelect_ff;
  logic [15:0] outStore_ff;
  logic [15:0] analogCfg_ff;
  logic [15:0] pinSample_ff;
  logic wbAck_ff;
  logic [31:0] rdData_ff;
  logic [15:0] padOut_ff;
  logic [15:0] padOutEn_n_ff;
  logic [15:0] periphOwns;
  logic [15:0] nxt_padOut;
  logic [15:0] nxt_padOutEn_n;
  logic [31:0] nxt_rdData;
  logic busReq;
  logic wrLo;
  logic wrHi;

  assign busReq = wb_cyc_i && wb_stb_i && !wbAck_ff;
  assign wrLo = busReq && wb_we_i && wb_sel_i[0];
  assign wrHi = busReq && wb_we_i && wb_sel_i[1];

  // direction register, all inputs after reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dirSelect_ff <= spio_pkg::DIR_RESET & IMPL_MASK;
    end else if (wb_adr_i == spio_pkg::OFS_DIR) begin
      if (wrLo) dirSelect_ff[7:0] <= wb_dat_i[7:0] & IMPL_MASK[7:0];
      if (wrHi) dirSelect_ff[15:8] <= wb_dat_i[15:8] & IMPL_MASK[15:8];
    end
  end

  // store latch, written via store or pin offset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      outStore_ff <= spio_pkg::STORE_RESET;
    end else if (wb_adr_i == spio_pkg::OFS_STORE || wb_adr_i == spio_pkg::OFS_PIN) begin
      if (wrLo) outStore_ff[7:0] <= wb_dat_i[7:0] & IMPL_MASK[7:0];
      if (wrHi) outStore_ff[15:8] <= wb_dat_i[15:8] & IMPL_MASK[15:8];
    end
  end

  // analog pin configuration
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      analogCfg_ff <= spio_pkg::ANALOG_RESET;
    end else if (wb_adr_i == spio_pkg::OFS_ANALOG) begin
      if (wrLo) analogCfg_ff[7:0] <= wb_dat_i[7:0] & IMPL_MASK[7:0];
      if (wrHi) analogCfg_ff[15:8] <= wb_dat_i[15:8] & IMPL_MASK[15:8];
    end
  end

  // pin sampling, analog and unimplemented bits forced low
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pinSample_ff <= '0;
    end else begin
      pinSample_ff <= padIn & IMPL_MASK & ~analogCfg_ff;
    end
  end

  // read data mux; unmapped offsets read zero
  always_comb begin
    nxt_rdData = '0;
    unique case (wb_adr_i)
      spio_pkg::OFS_DIR: nxt_rdData[15:0] = dirSelect_ff;
      spio_pkg::OFS_PIN: nxt_rdData[15:0] = pinSample_ff;
      spio_pkg::OFS_STORE: nxt_rdData[15:0] = outStore_ff;
      spio_pkg::OFS_ANALOG: nxt_rdData[15:0] = analogCfg_ff;
      spio_pkg::OFS_PERIPH: nxt_rdData[15:0] = periphOwns;
      default: nxt_rdData = '0;
    endcase
  end

  // wishbone ack one cycle after request, dropped next cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wbAck_ff <= 1'b0;
      rdData_ff <= '0;
    end else begin
      wbAck_ff <= busReq;
      rdData_ff <= busReq ? nxt_rdData : '0;
    end
  end

  // output ownership per pin
  genvar g;
  generate
    for (g = 0; g < spio_pkg::PORT_W; g++) begin : gPin
      if (IMPL_MASK[g] && SHARED_MASK[g]) begin : gShared
        // peripheral owns pin only while enabled and driving
        assign periphOwns[g] = periphEnable[g] && periphActive[g];
        assign nxt_padOut[g] = periphOwns[g] ? periphOut[g] : outStore_ff[g];
        assign nxt_padOutEn_n[g] = periphOwns[g] ? periphOutEn_n[g] : dirSelect_ff[g];
      end else if (IMPL_MASK[g]) begin : gDedicated
        // dedicated pin: port only
        assign periphOwns[g] = 1'b0;
        assign nxt_padOut[g] = outStore_ff[g];
        assign nxt_padOutEn_n[g] = dirSelect_ff[g];
      end else begin : gAbsent
        assign periphOwns[g] = 1'b0;
        assign nxt_padOut[g] = 1'b0;
        assign nxt_padOutEn_n[g] = 1'b1;
      end
    end
  endgenerate

  // registered pad drive
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      padOut_ff <= '0;
      padOutEn_n_ff <= '1;
    end else begin
      padOut_ff <= nxt_padOut;
      padOutEn_n_ff <= nxt_padOutEn_n;
    end
  end

  assign padOut = padOut_ff;
  assign padOutEn_n = padOutEn_n_ff;
  assign wb_ack_o = wbAck_ff;
  assign wb_dat_o = rdData_ff;

  // bus handshake steps: request taken, ack pulse, ack gone
  sequence spio_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  endsequence
  sequence spio_read_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  endsequence
  sequence spio_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence spio_idle_s;
    !wb_ack_o;
  endsequence

  // pads released right after reset
  chk_reset_inputs: assert property (@(posedge mclk)
    !reset_n |=> padOutEn_n == 16'hFFFF)
    else $error("pins not inputs after reset");

  // direction register back to all inputs
  chk_reset_dir: assert property (@(posedge mclk)
    !reset_n |=> dirSelect_ff == (spio_pkg::DIR_RESET & IMPL_MASK))
    else $error("direction not reset");

  // store latch and pad data cleared by reset
  chk_reset_store: assert property (@(posedge mclk)
    !reset_n |=> outStore_ff == spio_pkg::STORE_RESET && padOut == 16'h0000)
    else $error("store not reset");

  // bus quiet after reset
  chk_reset_ack: assert property (@(posedge mclk)
    !reset_n |=> spio_idle_s)
    else $error("ack during reset");

  // direction one keeps the port driver off
  chk_dir_input: assert property (@(posedge mclk) disable iff (!reset_n)
    (dirSelect_ff[0] && !periphOwns[0]) |=> padOutEn_n[0])
    else $error("input pin driven");

  // direction zero turns the port driver on
  chk_dir_output: assert property (@(posedge mclk) disable iff (!reset_n)
    (!dirSelect_ff[0] && !periphOwns[0]) |=> !padOutEn_n[0])
    else $error("output pin not driven");

  // port-owned pin follows latch and direction
  chk_port_drive: assert property (@(posedge mclk) disable iff (!reset_n)
    !periphOwns[0] |=> padOut[0] == $past(outStore_ff[0]) && padOutEn_n[0] == $past(dirSelect_ff[0]))
    else $error("port drive mismatch");

  // port data on an upper pin
  chk_port_data: assert property (@(posedge mclk) disable iff (!reset_n)
    !periphOwns[9] |=> padOut[9] == $past(outStore_ff[9]))
    else $error("port data mismatch");

  // active peripheral takes the pin data
  chk_periph_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    (periphEnable[0] && periphActive[0]) |=> padOut[0] == $past(periphOut[0]))
    else $error("peripheral lost pin");

  // enabled but idle peripheral leaves the pin to the port
  chk_periph_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (periphEnable[4] && !periphActive[4]) |=> padOut[4] == $past(outStore_ff[4]))
    else $error("idle peripheral kept pin");

  // peripheral enable reaches the pad
  chk_periph_oe: assert property (@(posedge mclk) disable iff (!reset_n)
    periphOwns[2] |=> padOutEn_n[2] == $past(periphOutEn_n[2]))
    else $error("peripheral enable not muxed");

  // unshared pin ignores an active peripheral
  chk_dedicated_pin: assert property (@(posedge mclk) disable iff (!reset_n)
    (periphEnable[9] && periphActive[9] && !SHARED_MASK[9]) |=> padOut[9] == $past(outStore_ff[9]))
    else $error("dedicated pin muxed");

  // analog pin samples low
  chk_analog_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    analogCfg_ff[3] |=> !pinSample_ff[3])
    else $error("analog pin read high");

  // analog bits read back cleared
  chk_analog_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (busReq && !wb_we_i && wb_adr_i == spio_pkg::OFS_PIN) |=> (wb_dat_o[15:0] & $past(analogCfg_ff)) == 16'h0000)
    else $error("analog bit read set");

  // digital pin level reaches the sample
  chk_pin_live: assert property (@(posedge mclk) disable iff (!reset_n)
    !analogCfg_ff[0] |=> pinSample_ff[0] == $past(padIn[0]))
    else $error("pin level lost");

  // pin offset write lands in the latch
  chk_pin_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrLo && wb_adr_i == spio_pkg::OFS_PIN) |=> outStore_ff[7:0] == $past(wb_dat_i[7:0] & IMPL_MASK[7:0]))
    else $error("pin write missed store");

  // store offset write lands in the latch
  chk_store_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrLo && wb_adr_i == spio_pkg::OFS_STORE) |=> outStore_ff[7:0] == $past(wb_dat_i[7:0] & IMPL_MASK[7:0]))
    else $error("store write missed");

  // latch keeps its value without a write
  chk_store_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !wrLo |=> outStore_ff[7:0] == $past(outStore_ff[7:0]))
    else $error("store changed unasked");

  // direction write lands
  chk_dir_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrHi && wb_adr_i == spio_pkg::OFS_DIR) |=> dirSelect_ff[15:8] == $past(wb_dat_i[15:8] & IMPL_MASK[15:8]))
    else $error("direction write missed");

  // store read returns latch, not pins
  chk_store_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (busReq && !wb_we_i && wb_adr_i == spio_pkg::OFS_STORE) |=> wb_ack_o && wb_dat_o[15:0] == $past(outStore_ff))
    else $error("store read wrong");

  // pin read returns the sample
  chk_pin_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (busReq && !wb_we_i && wb_adr_i == spio_pkg::OFS_PIN) |=> wb_dat_o[15:0] == $past(pinSample_ff))
    else $error("pin read wrong");

  // direction read returns the register
  chk_dir_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (busReq && !wb_we_i && wb_adr_i == spio_pkg::OFS_DIR) |=> wb_dat_o[15:0] == $past(dirSelect_ff))
    else $error("direction read wrong");

  // unimplemented bits stay clear
  chk_unimpl_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    ((dirSelect_ff | outStore_ff | pinSample_ff) & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented bit set");

  // unimplemented pads never driven
  chk_unimpl_pads: assert property (@(posedge mclk) disable iff (!reset_n)
    (padOutEn_n | IMPL_MASK) == 16'hFFFF)
    else $error("unimplemented pad driven");

  // upper read lanes always zero
  chk_upper_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    wb_dat_o[31:16] == 16'h0000)
    else $error("upper read lanes set");

  // write answered by a one-cycle ack
  chk_write_acked: assert property (@(posedge mclk) disable iff (!reset_n)
    spio_write_s |=> spio_ack_s)
    else $error("write not acked");

  // read answered by a one-cycle ack
  chk_read_acked: assert property (@(posedge mclk) disable iff (!reset_n)
    spio_read_s |=> spio_ack_s)
    else $error("read not acked");

  // read data zero outside ack
  chk_dat_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    spio_idle_s |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
endmodule
`default_nettype wire

// ---- test/spio_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spio_periph_model (
  input wire logic mclk,
  input wire logic [15:0] enMask,
  input wire logic [15:0] drvMask,
  output logic [15:0] periphEnable,
  output logic [15:0] periphActive,
  output logic [15:0] periphOut,
  output logic [15:0] periphOutEn_n
);
  logic [15:0] churn_ff = 16'h0000;
  // undriven data churns so a stale value never passes
  always @(posedge mclk) begin
    churn_ff <= ~churn_ff;
  end
  // fixed pattern and low enable only where actively driving
  assign periphEnable = enMask;
  assign periphActive = enMask & drvMask;
  assign periphOut = (drvMask & 16'hA5C3) | (~drvMask & churn_ff);
  assign periphOutEn_n = ~(enMask & drvMask);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] padIn = 16'hBEEF;
  logic [15:0] padOut, padOutEn_n, pEn, pAct, pOut, pOen_n;
  logic [15:0] enMask = 16'h0000;
  logic [15:0] drvMask = 16'h0000;
  int num_errors = 0;
  int checks = 0;
  spio_port #(.IMPL_MASK(16'h7FFF), .SHARED_MASK(16'h00FF)) u_dut (.mclk(mclk),
    .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .padIn(padIn),
    .padOut(padOut), .padOutEn_n(padOutEn_n), .periphEnable(pEn), .periphActive(pAct),
    .periphOut(pOut), .periphOutEn_n(pOen_n));
  spio_periph_model u_model (.mclk(mclk), .enMask(enMask), .drvMask(drvMask),
    .periphEnable(pEn), .periphActive(pAct), .periphOut(pOut), .periphOutEn_n(pOen_n));
  // free-running 250 MHz clock
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    @(posedge mclk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 40) begin
        num_errors++;
        tally_and_finish();
      end
      @(posedge mclk);
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {16'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, {16'h0, exp});
  endtask
  task automatic pads(input logic [15:0] expOut, input logic [15:0] expEn_n);
    repeat (2) @(posedge mclk);
    chk({16'h0, padOutEn_n}, {16'h0, expEn_n});
    chk({16'h0, padOut & ~padOutEn_n}, {16'h0, expOut & ~expEn_n});
  endtask
  task automatic reset_state();
    rd(spio_pkg::OFS_DIR, 16'h7FFF);
    rd(spio_pkg::OFS_STORE, 16'h0000);
    pads(16'h0000, 16'hFFFF);
  endtask
  task automatic port_drive();
    wr(spio_pkg::OFS_DIR, 16'h00F0);
    wr(spio_pkg::OFS_STORE, 16'hF234);
    rd(spio_pkg::OFS_STORE, 16'h7234);
    rd(spio_pkg::OFS_DIR, 16'h00F0);
    pads(16'h7234, 16'h80F0);
  endtask
  task automatic pin_path();
    wr(spio_pkg::OFS_PIN, 16'h0F0F);
    rd(spio_pkg::OFS_STORE, 16'h0F0F);
    rd(spio_pkg::OFS_PIN, 16'h3EEF);
    wr(spio_pkg::OFS_DIR, 16'h00FF);
    wr(spio_pkg::OFS_ANALOG, 16'h00FF);
    rd(spio_pkg::OFS_PIN, 16'h3E00);
    wr(spio_pkg::OFS_ANALOG, 16'h0000);
    rd(8'h14, 16'h0000);
  endtask
  task automatic sharing();
    wr(spio_pkg::OFS_DIR, 16'h0000);
    wr(spio_pkg::OFS_STORE, 16'h0000);
    enMask <= 16'hFFFF;
    drvMask <= 16'h0F0F;
    pads(16'h0003, 16'h8000);
    rd(spio_pkg::OFS_PIN, 16'h3EEF);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    reset_state();
    port_drive();
    pin_path();
    sharing();
    tally_and_finish();
  end
endmodule
`default_nettype wire
